// ==== inc/pwd_map.svh ====
// Register addresses, field positions, reset values and timing counts of the watchdog control block.
`ifndef PWD_MAP_SVH
`define PWD_MAP_SVH
`define PWD_ADDR_CTRL        8'hC0
`define PWD_ADDR_KEY         8'hBB
`define PWD_ADDR_PROT        8'hBC
`define PWD_CTRL_RESET       8'h72
`define PWD_PROT_RESET       8'hFF
`define PWD_KEY_RESET        8'h00
`define PWD_BIT_WR_EN        0
`define PWD_BIT_ENABLE       1
`define PWD_BIT_FLAG         2
`define PWD_BIT_IRQ_SEL      3
`define PWD_BIT_LOCK         7
`define PWD_PRE_BASE_SHIFT   5'd9
`define PWD_PRE_LAST_TIMED   4'h7
`define PWD_PRE_AUTO_RESET   4'h8
`define PWD_PRE_DL_RESET     4'h9
`define PWD_FLASH_TOP        14'h3FFF
`define PWD_FLASH_BYTES      3'd5
`define PWD_CNT_ONE          16'h0001
`endif

// ==== inc/pwd_pkg.sv ====
// Types shared by the protected watchdog control block.
package pwd_pkg;
    typedef struct packed {
        logic [3:0] prescale;
        logic       timeout_irq_select;
        logic       timeout_flag;
        logic       dog_enable;
        logic       guarded_write_enable;
    } pwd_ctrl_t;

    typedef struct packed {
        logic       lock_and_key_msb;
        logic [6:0] flash_key_low_bits;
    } pwd_prot_t;

    typedef enum logic [1:0] {
        PWD_GUARD_IDLE   = 2'b00,
        PWD_GUARD_ARMING = 2'b01,
        PWD_GUARD_OPEN   = 2'b10
    } pwd_guard_t;

    typedef enum logic [1:0] {
        PWD_FL_IDLE  = 2'b00,
        PWD_FL_WRITE = 2'b01
    } pwd_flash_t;
endpackage

// ==== hdl/pwd_watchdog.sv ====
// Protected watchdog control: guarded control register, lock, timeout and flash protection commit.
`timescale 1ns/1ps
`include "pwd_map.svh"
`default_nettype none

module pwd_watchdog (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    input  wire logic        instr_end,
    input  wire logic        xtal_tick,
    input  wire logic        prot_commit_req,
    input  wire logic [39:0] prot_new_bytes,
    output var  logic [7:0]  sfr_rdata,
    output var  logic        sys_reset_req,
    output var  logic        download_reset_req,
    output var  logic        wdt_irq,
    output var  logic        flash_wr_stb,
    output var  logic [13:0] flash_wr_addr,
    output var  logic [7:0]  flash_wr_data,
    output var  logic        prot_key_fail
);

    // Timeout compare value for the timed prescaler codes.
    function automatic logic [15:0] last_count(input logic [3:0] pre);
        logic [4:0] sh;
        sh = `PWD_PRE_BASE_SHIFT + {1'b0, pre};
        last_count = 16'((32'h1 << sh) - 32'h1);
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] want);
        hit = (addr == want);
    endfunction

    pwd_pkg::pwd_ctrl_t  ctrl_reg, ctrl_next;
    pwd_pkg::pwd_prot_t  prot_reg, prot_next;
    pwd_pkg::pwd_guard_t guard_reg, guard_next;
    pwd_pkg::pwd_flash_t fl_reg, fl_next;
    logic [7:0]  key_reg, key_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [2:0]  fl_idx_reg, fl_idx_next;
    logic [39:0] fl_data_reg, fl_data_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        sysrst_reg, sysrst_next;
    logic        dlrst_reg, dlrst_next;
    logic        irq_reg, irq_next;
    logic        fstb_reg, fstb_next;
    logic [13:0] faddr_reg, faddr_next;
    logic [7:0]  fdata_reg, fdata_next;
    logic        kfail_reg, kfail_next;

    logic ctrl_wr;
    logic timeout;
    logic locked;

    assign ctrl_wr = sfr_wr && hit(sfr_addr, `PWD_ADDR_CTRL);
    assign locked  = !prot_reg.lock_and_key_msb;
    // A timeout is only reachable for the timed codes; invalid codes never expire.
    assign timeout = ctrl_reg.dog_enable && xtal_tick
                     && (ctrl_reg.prescale <= `PWD_PRE_LAST_TIMED)
                     && (cnt_reg == last_count(ctrl_reg.prescale));

    // Guard sequencer: arming is seen in the instruction that sets the bit, the window opens in the next.
    always_comb begin
        guard_next = guard_reg;
        case (guard_reg)
            pwd_pkg::PWD_GUARD_IDLE: begin
                if (ctrl_wr && sfr_wdata[`PWD_BIT_WR_EN]) begin
                    guard_next = instr_end ? pwd_pkg::PWD_GUARD_OPEN : pwd_pkg::PWD_GUARD_ARMING;
                end
            end
            pwd_pkg::PWD_GUARD_ARMING: begin
                if (instr_end) begin
                    guard_next = pwd_pkg::PWD_GUARD_OPEN;
                end
            end
            pwd_pkg::PWD_GUARD_OPEN: begin
                if (instr_end) begin
                    guard_next = pwd_pkg::PWD_GUARD_IDLE;
                end
            end
            default: begin
                guard_next = pwd_pkg::PWD_GUARD_IDLE;
            end
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        cnt_next  = cnt_reg;
        ctrl_next.guarded_write_enable = (guard_next != pwd_pkg::PWD_GUARD_IDLE);
        if (ctrl_reg.dog_enable && xtal_tick) begin
            cnt_next = cnt_reg + `PWD_CNT_ONE;
        end
        if (timeout) begin
            cnt_next = '0;
        end
        // Writes outside the open window are dropped; this is the upset protection.
        if (ctrl_wr && guard_reg == pwd_pkg::PWD_GUARD_OPEN) begin
            ctrl_next.prescale = sfr_wdata[7:4];
            if (!locked) begin
                ctrl_next.timeout_irq_select = sfr_wdata[`PWD_BIT_IRQ_SEL];
                ctrl_next.dog_enable         = sfr_wdata[`PWD_BIT_ENABLE];
            end
            if (!sfr_wdata[`PWD_BIT_FLAG]) begin
                ctrl_next.timeout_flag = 1'b0;
            end
            if (sfr_wdata[`PWD_BIT_ENABLE]) begin
                cnt_next = '0;
            end
        end
        if (locked) begin
            ctrl_next.timeout_irq_select = 1'b0;
            ctrl_next.dog_enable         = 1'b1;
        end
        if (timeout) begin
            ctrl_next.timeout_flag = 1'b1;
        end
    end

    // Timeout reset and irq are one-cycle pulses; auto and download resets hold while their code is set and the dog is enabled;
    // the core's reset logic must not reset this block.
    always_comb begin
        sysrst_next = 1'b0;
        dlrst_next  = 1'b0;
        irq_next    = 1'b0;
        if (timeout) begin
            if (ctrl_reg.timeout_irq_select) begin
                irq_next = 1'b1;
            end else begin
                sysrst_next = 1'b1;
            end
        end
        if (ctrl_reg.dog_enable && ctrl_reg.prescale == `PWD_PRE_AUTO_RESET) begin
            sysrst_next = 1'b1;
        end
        if (ctrl_reg.dog_enable && ctrl_reg.prescale == `PWD_PRE_DL_RESET) begin
            dlrst_next = 1'b1;
        end
    end

    // Key register, protection byte and the flash commit sequence.
    always_comb begin
        key_next     = key_reg;
        prot_next    = prot_reg;
        fl_next      = fl_reg;
        fl_idx_next  = fl_idx_reg;
        fl_data_next = fl_data_reg;
        fstb_next    = 1'b0;
        faddr_next   = faddr_reg;
        fdata_next   = fdata_reg;
        kfail_next   = 1'b0;
        if (sfr_wr && hit(sfr_addr, `PWD_ADDR_KEY)) begin
            key_next = sfr_wdata;
        end
        if (sfr_wr && hit(sfr_addr, `PWD_ADDR_PROT)) begin
            prot_next = sfr_wdata;
        end
        case (fl_reg)
            pwd_pkg::PWD_FL_IDLE: begin
                if (prot_commit_req) begin
                    if (prot_reg == key_reg) begin
                        fl_next      = pwd_pkg::PWD_FL_WRITE;
                        fl_idx_next  = '0;
                        fl_data_next = prot_new_bytes;
                    end else begin
                        kfail_next = 1'b1;
                    end
                end
            end
            pwd_pkg::PWD_FL_WRITE: begin
                fstb_next    = 1'b1;
                faddr_next   = `PWD_FLASH_TOP - 14'(fl_idx_reg);
                fdata_next   = fl_data_reg[39:32];
                fl_data_next = {fl_data_reg[31:0], 8'h00};
                fl_idx_next  = fl_idx_reg + 3'd1;
                if (fl_idx_reg == `PWD_FLASH_BYTES - 3'd1) begin
                    fl_next = pwd_pkg::PWD_FL_IDLE;
                end
            end
            default: begin
                fl_next = pwd_pkg::PWD_FL_IDLE;
            end
        endcase
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd) begin
            if (hit(sfr_addr, `PWD_ADDR_CTRL)) begin
                rdata_next = ctrl_reg;
            end else if (hit(sfr_addr, `PWD_ADDR_KEY)) begin
                rdata_next = key_reg;
            end else if (hit(sfr_addr, `PWD_ADDR_PROT)) begin
                rdata_next = prot_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg    <= `PWD_CTRL_RESET;
            prot_reg    <= `PWD_PROT_RESET;
            guard_reg   <= pwd_pkg::PWD_GUARD_IDLE;
            fl_reg      <= pwd_pkg::PWD_FL_IDLE;
            key_reg     <= `PWD_KEY_RESET;
            cnt_reg     <= '0;
            fl_idx_reg  <= '0;
            fl_data_reg <= '0;
            rdata_reg   <= '0;
            sysrst_reg  <= 1'b0;
            dlrst_reg   <= 1'b0;
            irq_reg     <= 1'b0;
            fstb_reg    <= 1'b0;
            faddr_reg   <= '0;
            fdata_reg   <= '0;
            kfail_reg   <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            prot_reg    <= prot_next;
            guard_reg   <= guard_next;
            fl_reg      <= fl_next;
            key_reg     <= key_next;
            cnt_reg     <= cnt_next;
            fl_idx_reg  <= fl_idx_next;
            fl_data_reg <= fl_data_next;
            rdata_reg   <= rdata_next;
            sysrst_reg  <= sysrst_next;
            dlrst_reg   <= dlrst_next;
            irq_reg     <= irq_next;
            fstb_reg    <= fstb_next;
            faddr_reg   <= faddr_next;
            fdata_reg   <= fdata_next;
            kfail_reg   <= kfail_next;
        end
    end

    assign sfr_rdata          = rdata_reg;
    assign sys_reset_req      = sysrst_reg;
    assign download_reset_req = dlrst_reg;
    assign wdt_irq            = irq_reg;
    assign flash_wr_stb       = fstb_reg;
    assign flash_wr_addr      = faddr_reg;
    assign flash_wr_data      = fdata_reg;
    assign prot_key_fail      = kfail_reg;

endmodule

`default_nettype wire

// ==== verification/pwd_watchdog_sva.sv ====
// Concurrent checks on the ports of the protected watchdog control block.
`timescale 1ns/1ps
`include "pwd_map.svh"
`default_nettype none
module pwd_watchdog_chk (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sys_reset_req,
    input wire logic        download_reset_req,
    input wire logic        wdt_irq,
    input wire logic        flash_wr_stb,
    input wire logic [13:0] flash_wr_addr,
    input wire logic        prot_key_fail
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_run_start;
        !flash_wr_stb ##1 flash_wr_stb;
    endsequence
    a_flash_top: assert property (s_run_start |-> flash_wr_addr == 14'h3FFF)
        else $error("flash run did not start at the top byte");
    a_flash_step: assert property (flash_wr_stb && flash_wr_addr != 14'h3FFB
        |=> flash_wr_stb && flash_wr_addr == $past(flash_wr_addr) - 14'h0001) else $error("flash run broke");
    a_flash_last: assert property (flash_wr_stb && flash_wr_addr == 14'h3FFB |=> !flash_wr_stb)
        else $error("flash run too long");
    a_fail_nowrite: assert property (prot_key_fail |-> !flash_wr_stb ##1 !flash_wr_stb)
        else $error("flash written after key mismatch");
    a_irq_pulse: assert property (wdt_irq |=> !wdt_irq)
        else $error("interrupt longer than one cycle");
    a_irq_noreset: assert property (wdt_irq |-> !sys_reset_req && !download_reset_req)
        else $error("reset together with interrupt");
    a_reset_excl: assert property (download_reset_req |-> !sys_reset_req)
        else $error("both reset kinds at once");
    a_rd_unmapped: assert property (sfr_rd && !(sfr_addr inside {8'hC0, 8'hBB, 8'hBC})
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_rd_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
endmodule
bind pwd_watchdog pwd_watchdog_chk u_chk (.clk_sys, .arst_n, .sfr_addr, .sfr_rd, .sfr_rdata, .sys_reset_req,
    .download_reset_req, .wdt_irq, .flash_wr_stb, .flash_wr_addr, .prot_key_fail);
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench for the protected watchdog control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_rd = 1'b0;
    logic        instr_end = 1'b0;
    logic        xtal_tick = 1'b0;
    logic        prot_commit_req = 1'b0;
    logic [39:0] prot_new_bytes = 40'h0;
    logic [7:0]  sfr_rdata, flash_wr_data;
    logic        sys_reset_req, download_reset_req, wdt_irq, flash_wr_stb, prot_key_fail;
    logic [13:0] flash_wr_addr;
    logic        rd_pend = 1'b0;
    logic [7:0]  rd_q[$];
    logic [21:0] fl_q[$];
    logic [3:0]  pre;
    logic [39:0] nb;
    int          err_total = 0, n_tests = 0, n_irq = 0, n_rst = 0, n_fail = 0;
    always #20 clk_sys = ~clk_sys;
    pwd_watchdog u_dut (.clk_sys, .arst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .instr_end, .xtal_tick,
        .prot_commit_req, .prot_new_bytes, .sfr_rdata, .sys_reset_req, .download_reset_req, .wdt_irq,
        .flash_wr_stb, .flash_wr_addr, .flash_wr_data, .prot_key_fail);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        instr_end = e;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        instr_end = 1'b0;
    endtask
    task automatic gw(input logic [7:0] d);
        wr(8'hC0, 8'h01, 1'b1);
        wr(8'hC0, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        rd_q.push_back(e);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            xtal_tick = 1'b1;
            @(negedge clk_sys);
            xtal_tick = 1'b0;
        end
    endtask
    task automatic commit;
        @(negedge clk_sys);
        prot_commit_req = 1'b1;
        @(negedge clk_sys);
        prot_commit_req = 1'b0;
    endtask
    // Pulses are counted with non-blocking updates so the main sequence can zero them at a falling edge.
    always @(posedge clk_sys) begin
        rd_pend <= sfr_rd;
        n_irq <= n_irq + int'(wdt_irq);
        n_rst <= n_rst + int'(sys_reset_req);
        n_fail <= n_fail + int'(prot_key_fail);
    end
    always @(negedge clk_sys) begin
        if (rd_pend) chk("sfr_rdata", rd_q.pop_front(), sfr_rdata);
        if (flash_wr_stb) chk("flash", fl_q.size() > 0 ? fl_q.pop_front() : 22'h0, {flash_wr_addr, flash_wr_data});
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(35383));
        cyc(20);
        arst_n = 1'b1;
        rd(8'hC0, 8'h72);
        rd(8'hBC, 8'hFF);
        rd(8'hBB, 8'h00);
        rd(8'h55, 8'h00);
        $display("test reset values done");
        wr(8'hC0, 8'h08, 1'b1);
        rd(8'hC0, 8'h72);
        wr(8'hC0, 8'h01, 1'b0);
        rd(8'hC0, 8'h73);
        wr(8'h55, 8'h00, 1'b1);
        wr(8'h55, 8'h00, 1'b1);
        wr(8'hC0, 8'h08, 1'b1);
        rd(8'hC0, 8'h72);
        $display("test guard done");
        gw(8'h0A);
        n_irq = 0;
        tick(1024);
        cyc(4);
        chk("irq count", 2, n_irq);
        chk("reset count", 0, n_rst);
        rd(8'hC0, 8'h0E);
        gw(8'h0A);
        tick(400);
        gw(8'h0A);
        n_irq = 0;
        tick(511);
        cyc(4);
        chk("irq early", 0, n_irq);
        tick(1);
        cyc(4);
        chk("irq on time", 1, n_irq);
        $display("test periodic done");
        pre = 4'($urandom % 2);
        gw({pre, 4'h2});
        n_rst = 0;
        n_irq = 0;
        tick((512 << pre) - 1);
        cyc(4);
        chk("reset early", 0, n_rst);
        tick(1);
        cyc(4);
        chk("reset count", 1, n_rst);
        chk("irq count", 0, n_irq);
        rd(8'hC0, {pre, 4'h6});
        $display("test reset mode done");
        gw(8'h82);
        cyc(3);
        chk("auto reset", 1, sys_reset_req);
        gw(8'h92);
        cyc(3);
        chk("download reset", 1, download_reset_req);
        chk("auto reset", 0, sys_reset_req);
        gw(8'hA2);
        cyc(3);
        n_rst = 0;
        tick(600);
        chk("invalid code", 0, n_rst);
        gw(8'h70);
        rd(8'hC0, 8'h70);
        $display("test codes done");
        wr(8'hBC, 8'h7F, 1'b1);
        rd(8'hBC, 8'h7F);
        gw(8'h38);
        rd(8'hC0, 8'h32);
        $display("test lock done");
        wr(8'hBB, 8'h7F, 1'b1);
        nb = {8'($urandom), 32'($urandom)};
        prot_new_bytes = nb;
        for (int i = 0; i < 5; i++) fl_q.push_back({14'h3FFF - 14'(i), nb[39 - 8 * i -: 8]});
        commit();
        cyc(10);
        chk("flash left", 0, fl_q.size());
        wr(8'hBB, 8'h7E, 1'b1);
        n_fail = 0;
        commit();
        cyc(6);
        chk("key fail", 1, n_fail);
        $display("test flash done");
        // Still locked: the irq request below is ignored, so the timeout must reset the system.
        gw(8'h0A);
        n_irq = 0;
        n_rst = 0;
        tick(512);
        cyc(4);
        chk("locked irq", 0, n_irq);
        chk("locked reset", 1, n_rst);
        rd(8'hC0, 8'h06);
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        rd(8'hC0, 8'h72);
        rd(8'hBC, 8'hFF);
        $display("test pin reset done");
        summarize();
    end
endmodule
`default_nettype wire
